// ===== verilog/dss_pkg.sv
// dss_pkg: constants shared by the digital input start/stop logic.
// assumes a 250 MHz pclk; all times become cycle counts here.
package dss_pkg;
    localparam int DSS_NUM_IN = 4;
    localparam int DSS_FN_W = 3;
    localparam int DSS_DELAY_W = 10;
    localparam int DSS_CLK_MHZ = 250;

    // input function selector codes
    localparam logic [2:0] DSS_FN_OFF = 3'h0;
    localparam logic [2:0] DSS_FN_START = 3'h1;
    localparam logic [2:0] DSS_FN_STOP = 3'h2;
    localparam logic [2:0] DSS_FN_PSET0 = 3'h3;
    localparam logic [2:0] DSS_FN_PSET1 = 3'h4;
    localparam logic [2:0] DSS_FN_EXTALM = 3'h5;
    localparam logic [2:0] DSS_FN_START_R = 3'h6;
    localparam logic [2:0] DSS_FN_START_L = 3'h7;

    // analogue/digital input selection values that enable analogue start/stop
    localparam logic [2:0] DSS_AIN_ANA_A = 3'h6;
    localparam logic [2:0] DSS_AIN_ANA_B = 3'h7;

    // register offsets (APB byte addresses)
    localparam logic [7:0] DSS_OFF_FN = 8'h00;
    localparam logic [7:0] DSS_OFF_DELAY = 8'h04;
    localparam logic [7:0] DSS_OFF_CTRL = 8'h08;
    localparam logic [7:0] DSS_OFF_STATUS = 8'h0C;

    // field positions
    localparam int DSS_CTRL_AIN_LSB = 0;
    localparam int DSS_CTRL_AIN_W = 3;

    // reset values
    localparam logic [15:0] DSS_FN_RST = 16'h4321;  // in1=1 .. in4=4, one nibble each
    localparam logic [9:0] DSS_DELAY_RST = 10'h001;
    localparam logic [9:0] DSS_DELAY_MIN = 10'h001;
    localparam logic [9:0] DSS_DELAY_MAX = 10'h3E7;

    // timing
    localparam int DSS_SEC_NS = 1000000000;
    localparam int DSS_CLK_NS = 4;
    localparam int DSS_SEC_CYC = DSS_SEC_NS / DSS_CLK_NS;
    localparam int DSS_DEB_US = 10;
    localparam int DSS_DEB_CYC = (DSS_DEB_US * 1000 + DSS_CLK_NS - 1) / DSS_CLK_NS;

    typedef enum logic [1:0] {
        DSS_IDLE = 2'b00,
        DSS_RUN = 2'b01,
        DSS_STOPPING = 2'b10
    } dss_state_e;
endpackage

// ===== verilog/dss_debounce.sv
// dss_debounce: two-flop synchroniser and stable-count debouncer.
// assumes raw input is a slow contact level.
`timescale 1ns/1ps
module dss_debounce #(
    parameter int CYCLES = 2500
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // raw and cleaned level
    input wire logic raw,
    output logic clean
);
    localparam int CW = $clog2(CYCLES + 1);
    logic sync1;
    logic sync2;
    logic [CW-1:0] cnt;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
        end else begin
            sync1 <= raw;
            sync2 <= sync1;
        end
    end

    // output only moves after the level held for CYCLES clocks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= '0;
            clean <= 1'b0;
        end else if (sync2 == clean) begin
            cnt <= '0;
        end else if (cnt == CW'(CYCLES - 1)) begin
            cnt <= '0;
            clean <= sync2;
        end else begin
            cnt <= cnt + 1'b1;
        end
    end
endmodule // dss_debounce

// ===== verilog/dss_start_stop.sv
// dss_start_stop: four programmable digital inputs deciding start, stop,
// reset, parameter set and external alarm, plus analogue start/stop delay.
// assumes APB from a single master; contacts and comparators are static levels.
//
// Added by the designer: the address map and the APB register port.
`timescale 1ns/1ps
module dss_start_stop
    import dss_pkg::*;
#(
    parameter int SEC_CYC = dss_pkg::DSS_SEC_CYC,
    parameter int DEB_CYC = dss_pkg::DSS_DEB_CYC
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // contact inputs, high = closed to supply
    input wire logic [dss_pkg::DSS_NUM_IN-1:0] din_raw,
    // analogue comparator levels and external sequencing
    input wire logic ref_below_on,
    input wire logic ref_above_off,
    input wire logic stop_done,
    // outputs to the motor sequencer
    output logic start_req,
    output logic start_right,
    output logic start_left,
    output logic stop_req,
    output logic reset_pulse,
    output logic ext_alarm,
    output logic [1:0] param_set,
    output logic contactor_on,
    output logic ana_enable
);
    import dss_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // registers

    logic [DSS_FN_W-1:0] fn_sel [DSS_NUM_IN];
    logic [DSS_DELAY_W-1:0] delay_s;
    logic [DSS_CTRL_AIN_W-1:0] ain_sel;
    logic [DSS_NUM_IN-1:0] din;
    logic [DSS_NUM_IN-1:0] din_q;
    dss_state_e state;
    logic start_cond;
    logic conflict;
    logic stop_open;
    logic no_stop_cfg;
    logic ana_start_ok;
    logic ana_stop_now;

    wire logic wr_en = psel && penable && pwrite;
    wire logic rd_en = psel && penable && !pwrite;
    wire logic addr_ok = (paddr == DSS_OFF_FN) || (paddr == DSS_OFF_DELAY)
        || (paddr == DSS_OFF_CTRL) || (paddr == DSS_OFF_STATUS);

    // zero-wait slave; unmapped addresses answer with pslverr
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_ok;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < DSS_NUM_IN; i++) begin
                fn_sel[i] <= DSS_FN_RST[i*4 +: DSS_FN_W];
            end
        end else if (wr_en && paddr == DSS_OFF_FN) begin
            for (int i = 0; i < DSS_NUM_IN; i++) begin
                if (pstrb[i / 2]) begin
                    fn_sel[i] <= pwdata[i*4 +: DSS_FN_W];
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            delay_s <= DSS_DELAY_RST;
        end else if (wr_en && paddr == DSS_OFF_DELAY && pstrb[0] && pstrb[1]) begin
            // out of range writes clamp; wide values must not wrap to the minimum
            if (|pwdata[31:DSS_DELAY_W] || pwdata[DSS_DELAY_W-1:0] > DSS_DELAY_MAX) begin
                delay_s <= DSS_DELAY_MAX;
            end else if (pwdata[DSS_DELAY_W-1:0] < DSS_DELAY_MIN) begin
                delay_s <= DSS_DELAY_MIN;
            end else begin
                delay_s <= pwdata[DSS_DELAY_W-1:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ain_sel <= '0;
        end else if (wr_en && paddr == DSS_OFF_CTRL && pstrb[0]) begin
            ain_sel <= pwdata[DSS_CTRL_AIN_LSB +: DSS_CTRL_AIN_W];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                DSS_OFF_FN: begin
                    prdata <= {17'h0, fn_sel[3], 1'b0, fn_sel[2], 1'b0, fn_sel[1],
                        1'b0, fn_sel[0]};
                end
                DSS_OFF_DELAY: prdata <= {22'h0, delay_s};
                DSS_OFF_CTRL: prdata <= {29'h0, ain_sel};
                DSS_OFF_STATUS: begin
                    prdata <= {18'h0, state, param_set, din, contactor_on, ext_alarm,
                        conflict, stop_open, no_stop_cfg, ana_enable};
                end
                default: prdata <= 32'h0000_0000;
            endcase
        end else if (rd_en) begin
            prdata <= prdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // input conditioning

    for (genvar g = 0; g < DSS_NUM_IN; g++) begin : g_deb
        dss_debounce #(.CYCLES(DEB_CYC)) u_deb (
            .pclk(pclk),
            .presetn(presetn),
            .raw(din_raw[g]),
            .clean(din[g])
        );
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            din_q <= '0;
        end else begin
            din_q <= din;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // function decode

    logic any_start;
    logic any_right;
    logic any_left;
    logic any_edge;
    logic alarm_open;
    logic ps0;
    logic ps1;

    always_comb begin
        any_start = 1'b0;
        any_right = 1'b0;
        any_left = 1'b0;
        any_edge = 1'b0;
        stop_open = 1'b0;
        no_stop_cfg = 1'b1;
        alarm_open = 1'b0;
        ps0 = 1'b0;
        ps1 = 1'b0;
        for (int i = 0; i < DSS_NUM_IN; i++) begin
            case (fn_sel[i])
                DSS_FN_START: begin
                    any_start = any_start | din[i];
                    any_edge = any_edge | (din[i] & ~din_q[i]);
                end
                DSS_FN_START_R: begin
                    any_right = any_right | din[i];
                    any_edge = any_edge | (din[i] & ~din_q[i]);
                end
                DSS_FN_START_L: begin
                    any_left = any_left | din[i];
                    any_edge = any_edge | (din[i] & ~din_q[i]);
                end
                DSS_FN_STOP: begin
                    no_stop_cfg = 1'b0;
                    stop_open = stop_open | ~din[i];
                end
                DSS_FN_EXTALM: alarm_open = alarm_open | ~din[i];
                DSS_FN_PSET0: ps0 = ps0 | din[i];
                DSS_FN_PSET1: ps1 = ps1 | din[i];
                default: ;
            endcase
        end
    end

    // distinct start functions closed together cancel each other
    assign conflict = (32'(any_start) + 32'(any_right) + 32'(any_left)) > 32'd1;
    assign start_cond = (any_start | any_right | any_left) & ~conflict;
    // with no stop input configured nothing may start, which covers remote mode
    wire logic start_ok = !no_stop_cfg && !stop_open;

    ////////////////////////////////////////////////////////////////////////
    // analogue start/stop timing

    assign ana_enable = (ain_sel == DSS_AIN_ANA_A) || (ain_sel == DSS_AIN_ANA_B);

    logic [31:0] sec_cnt;
    logic [DSS_DELAY_W-1:0] on_s;
    logic [DSS_DELAY_W-1:0] off_s;
    wire logic sec_tick = (sec_cnt == 32'(SEC_CYC - 1));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sec_cnt <= '0;
        end else if (sec_tick) begin
            sec_cnt <= '0;
        end else begin
            sec_cnt <= sec_cnt + 32'd1;
        end
    end

    // per-level second counters restart whenever the level drops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            on_s <= '0;
            off_s <= '0;
        end else begin
            if (!ana_enable || !ref_below_on) begin
                on_s <= '0;
            end else if (sec_tick && !ana_start_ok) begin
                on_s <= on_s + 1'b1;
            end
            if (!ana_enable || !ref_above_off) begin
                off_s <= '0;
            end else if (sec_tick && !ana_stop_now) begin
                off_s <= off_s + 1'b1;
            end
        end
    end

    // strictly longer than the delay: up to one second beyond it
    assign ana_start_ok = !ana_enable || (on_s > delay_s);
    assign ana_stop_now = ana_enable && (off_s > delay_s);

    ////////////////////////////////////////////////////////////////////////
    // run sequencing

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= DSS_IDLE;
        end else begin
            case (state)
                DSS_IDLE: begin
                    if (start_cond && start_ok && ana_start_ok) begin
                        state <= DSS_RUN;
                    end
                end
                DSS_RUN: begin
                    if (stop_open || no_stop_cfg || conflict || ana_stop_now) begin
                        state <= DSS_STOPPING;
                    end
                end
                DSS_STOPPING: begin
                    if (stop_done) begin
                        state <= DSS_IDLE;
                    end
                end
                default: state <= DSS_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_req <= 1'b0;
            start_right <= 1'b0;
            start_left <= 1'b0;
            stop_req <= 1'b0;
            reset_pulse <= 1'b0;
            ext_alarm <= 1'b0;
            param_set <= 2'h0;
            contactor_on <= 1'b0;
        end else begin
            start_req <= (state == DSS_IDLE) && start_cond && start_ok && ana_start_ok;
            start_right <= (state == DSS_IDLE) && any_right && !conflict && start_ok
                && ana_start_ok;
            start_left <= (state == DSS_IDLE) && any_left && !conflict && start_ok
                && ana_start_ok;
            stop_req <= (state == DSS_STOPPING);
            reset_pulse <= any_edge;
            ext_alarm <= alarm_open;
            param_set <= {ps1, ps0};
            contactor_on <= (state != DSS_IDLE);
        end
    end
endmodule // dss_start_stop

// ===== tb/dss_props.sv
// dss_props: port-level checks of the start/stop input logic, bound to the top.
// assumes word-aligned APB accesses and contacts that change at clock edges.
`timescale 1ns/1ps
module dss_props
    import dss_pkg::*;
#(
    parameter int DEB_CYC = 2
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // contacts and sequencing
    input wire logic [dss_pkg::DSS_NUM_IN-1:0] din_raw,
    input wire logic stop_req,
    input wire logic reset_pulse,
    input wire logic contactor_on,
    input wire logic ana_enable
);
    logic [3:0] din_q;
    logic [7:0] stab;
    // only the four word offsets answer without error
    wire logic mapped = paddr inside {DSS_OFF_FN, DSS_OFF_DELAY, DSS_OFF_CTRL, DSS_OFF_STATUS};

    // cycles since the raw contacts last moved; a pulse sooner means no filtering
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            din_q <= 4'h0;
            stab <= 8'h00;
        end else begin
            din_q <= din_raw;
            stab <= (din_raw != din_q) ? 8'h00 : ((stab == 8'hFF) ? stab : stab + 8'h01);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_acc;
        psel && penable;
    endsequence
    sequence s_ctrl_wr;
        s_acc ##0 (pwrite && pstrb[0] && paddr == DSS_OFF_CTRL);
    endsequence

    a_ready_now: assert property (s_acc |-> pready)
        else $error("pready low in access");
    a_unmapped_err: assert property (s_acc |-> pslverr == !mapped)
        else $error("pslverr wrong for address");
    a_unmapped_read: assert property (s_acc ##0 (!pwrite && !mapped) |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    a_ana_on: assert property (s_ctrl_wr ##0 pwdata[2:0] >= DSS_AIN_ANA_A |=> ana_enable)
        else $error("analogue mode not entered");
    a_ana_off: assert property (s_ctrl_wr ##0 pwdata[2:0] < DSS_AIN_ANA_A |=> !ana_enable)
        else $error("analogue mode entered");
    a_stop_contactor: assert property (stop_req |-> contactor_on)
        else $error("contactor off while stopping");
    a_contactor_fall: assert property ($fell(contactor_on) |-> $past(stop_req))
        else $error("contactor dropped without stop");
    a_pulse_single: assert property (reset_pulse |=> !reset_pulse)
        else $error("reset pulse longer than a cycle");
    a_pulse_filtered: assert property (reset_pulse |-> stab >= DEB_CYC + 1)
        else $error("reset pulse before debounce");
endmodule // dss_props

bind dss_start_stop dss_props #(.DEB_CYC(DEB_CYC)) u_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .din_raw(din_raw), .stop_req(stop_req), .reset_pulse(reset_pulse),
    .contactor_on(contactor_on), .ana_enable(ana_enable)
);

// ===== tb/dss_contacts.sv
// dss_contacts: external switch contacts feeding the four digital inputs.
// assumes want changes at clock edges; bounce adds contact chatter.
`timescale 1ns/1ps
module dss_contacts (
    // clock
    input wire logic pclk,
    // commanded positions and chatter request
    input wire logic [3:0] want,
    input wire logic bounce,
    // contact levels, high = closed to supply
    output logic [3:0] din_raw
);
    logic [3:0] pos = 4'h0;
    logic [3:0] moved = 4'h0;
    logic [2:0] n = 3'h0;

    always @(posedge pclk) begin
        if (want != pos) begin
            pos <= want;
            moved <= want ^ pos;
            n <= bounce ? 3'h5 : 3'h0;
        end else if (n != 3'h0) begin
            n <= n - 3'h1;
        end
    end
    // chatter flips only the contacts that just moved, one cycle at a time
    assign din_raw = n[0] ? (pos ^ moved) : pos;
endmodule // dss_contacts

// ===== tb/tb_dss_start_stop.sv
// tb_dss_start_stop: self-checking bench for the start/stop input logic.
// assumes dss_contacts as the switch model and the bound dss_props checker.
`timescale 1ns/1ps
module tb_dss_start_stop;
    import dss_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
    logic ref_below_on = 0, ref_above_off = 0, stop_done = 0, bounce = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, rd, v, x = 32'h05E7;
    logic [31:0] cor[6] = '{32'h0, 32'h1, 32'h3E7, 32'h3E8, 32'h3FF, 32'h400};
    logic [3:0] pstrb = 4'hF, want = 4'h0, din_raw;
    logic [31:0] prdata;
    logic pready, pslverr, start_req, start_right, start_left, stop_req, reset_pulse;
    logic ext_alarm, contactor_on, ana_enable;
    logic [1:0] param_set;
    int failures = 0, n_tests = 0, cyc = 0, npulse = 0, p0;
    // 1 right, 2 left, 3 stop, 5 alarm, 6 contactor
    wire [7:0] o = {ana_enable, contactor_on, ext_alarm, reset_pulse,
                    stop_req, start_left, start_right, start_req};

    dss_start_stop #(.SEC_CYC(10), .DEB_CYC(2)) dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .din_raw(din_raw), .ref_below_on(ref_below_on), .ref_above_off(ref_above_off),
        .stop_done(stop_done), .start_req(start_req), .start_right(start_right),
        .start_left(start_left), .stop_req(stop_req), .reset_pulse(reset_pulse),
        .ext_alarm(ext_alarm), .param_set(param_set), .contactor_on(contactor_on),
        .ana_enable(ana_enable));
    dss_contacts u_contacts (.pclk(pclk), .want(want), .bounce(bounce), .din_raw(din_raw));

    initial forever #2 pclk = ~pclk;
    // counted on the falling edge so the bench never races the pulse
    always @(negedge pclk) if (reset_pulse === 1'b1) npulse <= npulse + 1;
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 10000) begin
            failures++;
            end_of_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs();
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        return x;
    endfunction
    function automatic logic [31:0] clampd(input logic [31:0] d);
        if (d == 0) return {22'h0, DSS_DELAY_MIN};
        if (d > {22'h0, DSS_DELAY_MAX}) return {22'h0, DSS_DELAY_MAX};
        return d;
    endfunction
    task chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
             output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // pready ends this wait; if pready never rises, only the bench timeout ends it
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, rd, er);
    endtask
    task rdc(input logic [7:0] a, input logic [31:0] e, input logic ee);
        apb(1'b0, a, 32'h0, rd, er);
        chk(rd, e);
        chk({31'h0, er}, {31'h0, ee});
    endtask
    task waitb(input int b, input logic val, input int lim);
        int k;
        k = 0;
        while (o[b] !== val && k < lim) begin
            @(posedge pclk);
            k++;
        end
        chk({31'h0, o[b]}, {31'h0, val});
    endtask
    task holdb(input int b, input logic val, input int n);
        logic ok;
        ok = 1'b1;
        repeat (n) begin
            @(posedge pclk);
            if (o[b] !== val) ok = 1'b0;
        end
        chk({31'h0, ok}, 32'h1);
    endtask
    task setin(input logic [3:0] w, input int settle);
        @(posedge pclk);
        want <= w;
        repeat (settle) @(posedge pclk);
    endtask
    task done_pulse();
        @(posedge pclk);
        stop_done <= 1'b1;
        @(posedge pclk);
        stop_done <= 1'b0;
    endtask
    task end_of_test();
        $display("counts: %0d compares, %0d mismatches", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rdc(DSS_OFF_FN, 32'h0000_4321, 1'b0);
        rdc(DSS_OFF_DELAY, 32'h1, 1'b0);
        rdc(DSS_OFF_CTRL, 32'h0, 1'b0);
        rdc(DSS_OFF_STATUS, 32'h4, 1'b0);
        rdc(8'h10, 32'h0, 1'b1);
        rdc(8'h02, 32'h0, 1'b1);
        wr(8'h14, 32'hFFFF_FFFF);
        chk({31'h0, er}, 32'h1);
        $display("end of test: reset values and map");
        foreach (cor[i]) begin
            wr(DSS_OFF_DELAY, cor[i]);
            rdc(DSS_OFF_DELAY, clampd(cor[i]), 1'b0);
        end
        repeat (6) begin
            v = xs() & 32'h3FF;
            wr(DSS_OFF_DELAY, v);
            rdc(DSS_OFF_DELAY, clampd(v), 1'b0);
        end
        for (int i = 0; i < 12; i++) begin
            v = (i < 8) ? i * 32'h1111 : xs() & 32'h7777;
            wr(DSS_OFF_FN, v);
            rdc(DSS_OFF_FN, v, 1'b0);
        end
        for (int i = 0; i < 8; i++) begin
            wr(DSS_OFF_CTRL, i);
            @(posedge pclk);
            chk({31'h0, ana_enable}, {31'h0, i >= 6});
        end
        $display("end of test: register fields");
        wr(DSS_OFF_CTRL, 32'h0);
        wr(DSS_OFF_FN, 32'h4321);
        wr(DSS_OFF_DELAY, 32'h1);
        bounce <= 1'b1;
        p0 = npulse;
        setin(4'b0001, 0);
        holdb(6, 1'b0, 30);
        chk(npulse - p0, 32'h1);
        setin(4'b0010, 20);
        setin(4'b0011, 0);
        waitb(0, 1'b1, 20);
        waitb(6, 1'b1, 5);
        setin(4'b0001, 0);
        waitb(3, 1'b1, 20);
        holdb(6, 1'b1, 20);
        done_pulse();
        waitb(6, 1'b0, 5);
        wr(DSS_OFF_FN, 32'h4301);
        holdb(6, 1'b0, 30);
        $display("end of test: start and stop");
        wr(DSS_OFF_FN, 32'h2726);
        setin(4'b1010, 20);
        setin(4'b1011, 0);
        waitb(1, 1'b1, 20);
        waitb(6, 1'b1, 5);
        setin(4'b1111, 0);
        waitb(3, 1'b1, 20);
        done_pulse();
        waitb(6, 1'b0, 5);
        holdb(6, 1'b0, 30);
        setin(4'b1110, 0);
        waitb(2, 1'b1, 20);
        waitb(6, 1'b1, 5);
        setin(4'b0110, 0);
        waitb(3, 1'b1, 20);
        done_pulse();
        wr(DSS_OFF_FN, 32'h2121);
        setin(4'b1010, 20);
        setin(4'b1110, 0);
        waitb(6, 1'b1, 20);
        setin(4'b1100, 0);
        waitb(3, 1'b1, 20);
        done_pulse();
        $display("end of test: direction and conflict");
        wr(DSS_OFF_FN, 32'h5521);
        setin(4'b1100, 0);
        waitb(5, 1'b0, 20);
        setin(4'b0100, 0);
        waitb(5, 1'b1, 20);
        setin(4'b1100, 0);
        waitb(5, 1'b0, 20);
        setin(4'b1000, 0);
        waitb(5, 1'b1, 20);
        wr(DSS_OFF_FN, 32'h4321);
        bounce <= 1'b0;
        repeat (4) begin
            v = xs();
            setin({v[1:0], 2'b10}, 12);
            chk({30'h0, param_set}, {30'h0, v[1:0]});
        end
        wr(DSS_OFF_FN, 32'h0321);
        setin(4'b1110, 12);
        chk({30'h0, param_set}, 32'h1);
        $display("end of test: alarm and parameter set");
        wr(DSS_OFF_FN, 32'h4321);
        wr(DSS_OFF_CTRL, 32'h6);
        setin(4'b0011, 0);
        holdb(6, 1'b0, 40);
        ref_below_on <= 1'b1;
        holdb(6, 1'b0, 10);
        waitb(6, 1'b1, 40);
        ref_below_on <= 1'b0;
        ref_above_off <= 1'b1;
        holdb(3, 1'b0, 10);
        waitb(3, 1'b1, 40);
        done_pulse();
        $display("end of test: analogue start and stop");
        end_of_test();
    end
endmodule // tb_dss_start_stop
